// File: rtl/cfs_sched.sv
// Overview of operation
// - input takes data frames, output sends them; payload maps to host words.
// - cyclic data frames repeat with spacing equal to the configured period.
// - cyclic output sends at once on start, then every period regardless of writes.
// - without new payload the previous frame contents are resent unchanged.
// - single-point and queued input keep received data for the next host read.
// - non-stream input drops received remote frames with no effect on reads.
// - stream input takes every data frame of the cluster for the host.
// - stream input also queues received remote frames for host reads.
// - non-stream output drops remote frames written by the host.
// - stream output sends only written frames, never repeats them.
// - immediate stream timing sends each frame as soon as the bus allows.
// - replay stream timing sends each frame at its own timestamp.
// - event output sends per write; period is the minimum spacing.
// - event output sends nothing more until another host write.
// - remote request frames belong to stream input and stream output; non-stream output never stores them.
// - stopped interface neither transmits nor acknowledges on the bus.
// - with trigger enabled, start waits for a fresh rising trigger edge.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module cfs_sched #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // start trigger and bus acknowledge enable
    input  wire logic                        trig_i,
    output logic                             ack_en_o,
    // frames toward the bus
    output logic                             tx_valid_o,
    output logic [cfs_pkg::ID_W-1:0]         tx_id_o,
    output logic                             tx_rtr_o,
    output logic [cfs_pkg::DATA_W-1:0]       tx_data_o,
    input  wire logic                        tx_done_i,
    // frames from the bus
    input  wire logic                        rx_valid_i,
    output logic                             rx_ready_o,
    input  wire logic [cfs_pkg::ID_W-1:0]    rx_id_i,
    input  wire logic                        rx_rtr_i,
    input  wire logic [cfs_pkg::DATA_W-1:0]  rx_data_i
);
    localparam int IW = cfs_pkg::ID_W;
    localparam int DW = cfs_pkg::DATA_W;
    localparam int FW = cfs_pkg::RXF_W;

    // ==========================================
    // registers and signals
    logic [31:0]              ctrl_reg;
    logic [cfs_pkg::PER_W-1:0] period_reg;
    logic [IW-1:0]            id_reg;
    logic [31:0]              txlo_reg;
    logic [31:0]              txhi_reg;
    logic [cfs_pkg::TS_W-1:0] txts_reg;
    logic [DW-1:0]            pay_reg;
    logic                     ev_pend_reg;
    logic                     st_full_reg;
    logic [IW-1:0]            st_id_reg;
    logic                     st_rtr_reg;
    logic [DW-1:0]            st_data_reg;
    logic [cfs_pkg::TS_W-1:0] st_ts_reg;
    logic [cfs_pkg::TS_W-1:0] now_reg;
    logic                     iface_reg;
    logic                     trig_reg;
    logic                     sess_prev_reg;
    logic                     sp_fresh_reg;
    logic [FW-1:0]            sp_frame_reg;
    cfs_pkg::cfs_state_t      state_reg;
    logic [31:0]              rd_data;
    logic                     req;
    logic                     wr_edge;
    logic                     rd_edge;
    logic                     host_write_call;
    logic                     host_read_call;
    logic                     host_start_call;
    logic                     is_out;
    logic                     is_event;
    logic                     is_stream;
    logic [1:0]               mode;
    logic                     sess_run;
    logic                     sess_go;
    logic                     per_zero;
    logic                     due_sched;
    logic                     due_stream;
    logic                     launch;
    logic                     rx_take;
    logic                     rx_match;
    logic                     fifo_push;
    logic                     fifo_out_valid;
    logic [FW-1:0]            fifo_out_data;
    logic [FW-1:0]            rx_head;
    logic                     rx_avail;
    logic                     cmd_rtr;

    // ==========================================
    // bus decode
    // request edge latches read data, ack edge commits
    assign req     = wb_cyc_i & wb_stb_i;
    assign wr_edge = req & wb_ack_o & wb_we_i;
    assign rd_edge = req & wb_ack_o & ~wb_we_i;
    assign host_write_call = wr_edge & (wb_adr_i == cfs_pkg::ADR_TXCMD);
    assign host_read_call  = rd_edge & (wb_adr_i == cfs_pkg::ADR_RXHI);
    assign host_start_call = wr_edge & (wb_adr_i == cfs_pkg::ADR_CTRL);
    assign cmd_rtr = wb_dat_i[cfs_pkg::CMD_RTR];

    // mode fields
    assign is_out    = ctrl_reg[cfs_pkg::CTRL_OUT];
    assign is_event  = ctrl_reg[cfs_pkg::CTRL_EVENT];
    assign mode      = ctrl_reg[cfs_pkg::CTRL_MODE +: 2];
    assign is_stream = (mode == cfs_pkg::MODE_STREAM);
    assign sess_run  = ctrl_reg[cfs_pkg::CTRL_RUN] & iface_reg;
    assign sess_go   = sess_run & ~sess_prev_reg;

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return res;
    endfunction : merge

    // ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o) wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
        end
    end

    // read mux, unmapped reads as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            cfs_pkg::ADR_CTRL:   rd_data = ctrl_reg;
            cfs_pkg::ADR_PERIOD: rd_data = 32'(period_reg);
            cfs_pkg::ADR_ID:     rd_data = 32'(id_reg);
            cfs_pkg::ADR_TXLO:   rd_data = txlo_reg;
            cfs_pkg::ADR_TXHI:   rd_data = txhi_reg;
            cfs_pkg::ADR_TXTS:   rd_data = txts_reg;
            cfs_pkg::ADR_STAT:   rd_data = {27'h0, ctrl_reg[cfs_pkg::CTRL_IFACE] & ~iface_reg,
                                            st_full_reg, rx_avail, sess_run, iface_reg};
            cfs_pkg::ADR_RXID:   rd_data = 32'({rx_head[FW-1], rx_head[DW +: IW]});
            cfs_pkg::ADR_RXLO:   rd_data = rx_head[31:0];
            cfs_pkg::ADR_RXHI:   rd_data = rx_head[63:32];
            default:             rd_data = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= cfs_pkg::CTRL_RST;
            period_reg <= cfs_pkg::PERIOD_RST;
            id_reg     <= cfs_pkg::ID_RST;
            txlo_reg   <= 32'h0000_0000;
            txhi_reg   <= 32'h0000_0000;
            txts_reg   <= 32'h0000_0000;
        end else if (wr_edge) begin
            case (wb_adr_i)
                cfs_pkg::ADR_CTRL:   ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
                cfs_pkg::ADR_PERIOD: period_reg <= cfs_pkg::PER_W'(merge(32'(period_reg),
                                                         wb_dat_i, wb_sel_i));
                cfs_pkg::ADR_ID:     id_reg <= IW'(merge(32'(id_reg), wb_dat_i, wb_sel_i));
                cfs_pkg::ADR_TXLO:   txlo_reg <= merge(txlo_reg, wb_dat_i, wb_sel_i);
                cfs_pkg::ADR_TXHI:   txhi_reg <= merge(txhi_reg, wb_dat_i, wb_sel_i);
                cfs_pkg::ADR_TXTS:   txts_reg <= merge(txts_reg, wb_dat_i, wb_sel_i);
                default:             ;
            endcase
        end
    end

    // ==========================================
    // interface start and stop
    // trigger edge only counts while a start is pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iface_reg     <= 1'b0;
            trig_reg      <= 1'b0;
            sess_prev_reg <= 1'b0;
        end else begin
            trig_reg      <= trig_i;
            sess_prev_reg <= sess_run;
            if (~ctrl_reg[cfs_pkg::CTRL_IFACE]) iface_reg <= 1'b0;
            else if (~iface_reg & ~host_start_call) begin
                if (~ctrl_reg[cfs_pkg::CTRL_TRIG] | (trig_i & ~trig_reg)) begin
                    iface_reg <= 1'b1;
                end
            end
        end
    end

    // bus acknowledge only while running
    assign ack_en_o = iface_reg;

    // free-running timebase for replay
    always_ff @(posedge clk_i) begin
        if (rst_i) now_reg <= '0;
        else now_reg <= now_reg + cfs_pkg::TS_W'(1);
    end

    // ==========================================
    // host writes: payload shadow, event request, stream holding
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pay_reg     <= '0;
            ev_pend_reg <= 1'b0;
            st_full_reg <= 1'b0;
            st_id_reg   <= '0;
            st_rtr_reg  <= 1'b0;
            st_data_reg <= '0;
            st_ts_reg   <= '0;
        end else begin
            if (host_write_call & is_out & ~is_stream & ~cmd_rtr) begin
                pay_reg <= {txhi_reg, txlo_reg};
            end
            // set wins over the launch clear
            if (host_write_call & is_out & ~is_stream & ~cmd_rtr & is_event) begin
                ev_pend_reg <= 1'b1;
            end else if (launch & ~is_stream) begin
                ev_pend_reg <= 1'b0;
            end
            // stream frame held until sent, refused while busy
            if (host_write_call & is_out & is_stream & ~st_full_reg) begin
                st_full_reg <= 1'b1;
                st_id_reg   <= wb_dat_i[IW-1:0];
                st_rtr_reg  <= cmd_rtr;
                st_data_reg <= {txhi_reg, txlo_reg};
                st_ts_reg   <= txts_reg;
            end else if (state_reg == cfs_pkg::ST_SEND & is_stream & tx_done_i) begin
                st_full_reg <= 1'b0;
            end else if (~is_stream | ~is_out) begin
                st_full_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // scheduling decisions
    cfs_period #(
        .W        (cfs_pkg::PER_W)
    ) u_period (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (launch & ~is_stream),
        .period_i (period_reg),
        .zero_o   (per_zero)
    );

    // cyclic: first at start then on every expiry; event: pending and spacing met
    always_comb begin
        due_sched = 1'b0;
        if (sess_run & is_out & ~is_stream) begin
            if (is_event) due_sched = ev_pend_reg & per_zero;
            else due_sched = sess_go | per_zero;
        end
    end

    // stream: immediate or at the frame timestamp
    always_comb begin
        due_stream = 1'b0;
        if (sess_run & is_out & is_stream & st_full_reg) begin
            if (ctrl_reg[cfs_pkg::CTRL_STIM +: 2] == cfs_pkg::STIM_IMMED) begin
                due_stream = 1'b1;
            end else begin
                due_stream = (now_reg >= st_ts_reg);
            end
        end
    end

    assign launch = (state_reg == cfs_pkg::ST_IDLE) & (due_sched | due_stream);

    // ==========================================
    // transmit state machine, frame held until done or interface stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= cfs_pkg::ST_IDLE;
            tx_valid_o <= 1'b0;
            tx_id_o    <= '0;
            tx_rtr_o   <= 1'b0;
            tx_data_o  <= '0;
        end else begin
            case (state_reg)
                cfs_pkg::ST_IDLE: begin
                    if (launch) begin
                        state_reg  <= cfs_pkg::ST_SEND;
                        tx_valid_o <= 1'b1;
                        tx_id_o    <= is_stream ? st_id_reg : id_reg;
                        tx_rtr_o   <= is_stream & st_rtr_reg;
                        tx_data_o  <= is_stream ? st_data_reg : pay_reg;
                    end
                end
                cfs_pkg::ST_SEND: begin
                    if (~iface_reg | tx_done_i) begin
                        state_reg  <= cfs_pkg::ST_GAP;
                        tx_valid_o <= 1'b0;
                    end
                end
                cfs_pkg::ST_GAP: begin
                    state_reg <= cfs_pkg::ST_IDLE;
                end
                default: begin
                    state_reg  <= cfs_pkg::ST_IDLE;
                    tx_valid_o <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // receive path
    // only input sessions keep frames; remote requests go to stream only
    assign rx_take  = rx_valid_i & rx_ready_o & iface_reg & ~is_out;
    assign rx_match = (rx_id_i == id_reg) & ~rx_rtr_i;
    assign fifo_push = rx_take & (is_stream |
                                  (mode == cfs_pkg::MODE_QUEUE & rx_match));

    // queued and stream frames buffered for host reads
    cfs_fifo #(
        .W           (FW),
        .DEPTH       (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (rx_ready_o),
        .in_data_i   ({rx_rtr_i, rx_id_i, rx_data_i}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (host_read_call & (mode != cfs_pkg::MODE_SP)),
        .out_data_o  (fifo_out_data)
    );

    // single-point keeps the latest value; a new frame wins over a read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_fresh_reg <= 1'b0;
            sp_frame_reg <= '0;
        end else if (rx_take & mode == cfs_pkg::MODE_SP & rx_match) begin
            sp_fresh_reg <= 1'b1;
            sp_frame_reg <= {rx_rtr_i, rx_id_i, rx_data_i};
        end else if (host_read_call & mode == cfs_pkg::MODE_SP) begin
            sp_fresh_reg <= 1'b0;
        end
    end

    // host-visible head of the receive side
    assign rx_head  = (mode == cfs_pkg::MODE_SP) ? sp_frame_reg : fifo_out_data;
    assign rx_avail = (mode == cfs_pkg::MODE_SP) ? sp_fresh_reg : fifo_out_valid;
endmodule : cfs_sched

// File: rtl/cfs_pkg.sv
package cfs_pkg;
    // ==========================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_PERIOD = 8'h04;
    localparam logic [7:0] ADR_ID     = 8'h08;
    localparam logic [7:0] ADR_TXLO   = 8'h0C;
    localparam logic [7:0] ADR_TXHI   = 8'h10;
    localparam logic [7:0] ADR_TXCMD  = 8'h14;
    localparam logic [7:0] ADR_TXTS   = 8'h18;
    localparam logic [7:0] ADR_STAT   = 8'h1C;
    localparam logic [7:0] ADR_RXID   = 8'h20;
    localparam logic [7:0] ADR_RXLO   = 8'h24;
    localparam logic [7:0] ADR_RXHI   = 8'h28;
    // ==========================================
    // control and command field positions
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_IFACE = 1;
    localparam int CTRL_OUT   = 2;
    localparam int CTRL_MODE  = 3;
    localparam int CTRL_EVENT = 5;
    localparam int CTRL_TRIG  = 6;
    localparam int CTRL_STIM  = 7;
    localparam int CMD_RTR    = 11;
    // ==========================================
    // modes and stream output timing
    localparam logic [1:0] MODE_SP     = 2'h0;
    localparam logic [1:0] MODE_QUEUE  = 2'h1;
    localparam logic [1:0] MODE_STREAM = 2'h2;
    localparam logic [1:0] STIM_IMMED  = 2'h0;
    // ==========================================
    // widths, reset values, timing
    localparam int ID_W   = 11;
    localparam int DATA_W = 64;
    localparam int TS_W   = 32;
    localparam int PER_W  = 24;
    localparam int RXF_W  = 1 + ID_W + DATA_W;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [10:0] ID_RST   = 11'h000;
    localparam int CLK_MHZ       = 20;
    localparam int TX_PERIOD_US  = 10;
    localparam logic [PER_W-1:0] PERIOD_RST = PER_W'(TX_PERIOD_US * CLK_MHZ);
    // ==========================================
    // transmit scheduler states, one bit flips per step except GAP back to IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_GAP  = 2'b11
    } cfs_state_t;
endpackage : cfs_pkg

// File: rtl/cfs_fifo.sv
`timescale 1ns/1ps
module cfs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          push;
    logic          pop;

    // handshakes and occupancy
    assign push = in_valid_i & in_ready_o;
    assign pop  = out_ready_i & out_valid_o;
    assign out_data_o = mem[rd_reg];
    always_comb begin
        cnt_next = cnt_reg;
        if (push & ~pop) cnt_next = cnt_reg + CW'(1);
        if (pop & ~push) cnt_next = cnt_reg - CW'(1);
    end

    // storage
    always_ff @(posedge clk_i) begin
        if (push) mem[wr_reg] <= in_data_i;
    end

    // pointers and flags, full and empty held in flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg      <= '0;
            rd_reg      <= '0;
            cnt_reg     <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            if (push) wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
            if (pop)  rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
            cnt_reg     <= cnt_next;
            in_ready_o  <= (cnt_next != CW'(DEPTH));
            out_valid_o <= (cnt_next != '0);
        end
    end
endmodule : cfs_fifo

// File: rtl/cfs_period.sv
`timescale 1ns/1ps
module cfs_period #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // reload and expiry
    input  wire logic         load_i,
    input  wire logic [W-1:0] period_i,
    output logic              zero_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // reload with period-1 so spacing equals period
    always_comb begin
        cnt_next = cnt_reg;
        if (load_i) cnt_next = (period_i == '0) ? '0 : period_i - W'(1);
        else if (cnt_reg != '0) cnt_next = cnt_reg - W'(1);
    end

    // counter, idle expired after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            zero_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            zero_o  <= (cnt_next == '0);
        end
    end
endmodule : cfs_period

// File: tb/cfs_sched_assertions.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module cfs_sched_assertions (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_ack_o,
    input wire logic                     ack_en_o,
    input wire logic                     tx_valid_o,
    input wire logic [cfs_pkg::ID_W-1:0] tx_id_o,
    input wire logic                     tx_done_i,
    input wire logic                     rx_valid_i,
    input wire logic                     rx_ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack unasked");
    stop_quiet_a: assert property (!ack_en_o [*2] |-> !tx_valid_o)
        else $error("sent while stopped");
    tx_start_a: assert property ($rose(tx_valid_o) |-> ack_en_o)
        else $error("launch while stopped");
    tx_hold_a: assert property (tx_valid_o && !tx_done_i
        |=> !ack_en_o || tx_valid_o && $stable(tx_id_o)) else $error("frame changed");
    tx_drop_a: assert property (tx_valid_o && tx_done_i |=> !tx_valid_o)
        else $error("frame kept");
    rx_full_a: assert property ($fell(rx_ready_o) |-> $past(rx_valid_i))
        else $error("full without push");
    cover property (tx_valid_o && tx_done_i);
    cover property ($fell(rx_ready_o));
    cover property ($fell(ack_en_o));
endmodule : cfs_sched_assertions
bind cfs_sched cfs_sched_assertions u_cfs_sched_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ack_en_o(ack_en_o),
    .tx_valid_o(tx_valid_o), .tx_id_o(tx_id_o), .tx_done_i(tx_done_i),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o));

// File: tb/cfs_bus_model.sv
`timescale 1ns/1ps
// ==========================================
// remote controller ending each frame
module cfs_bus_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] lat_i,
    output logic            tx_done_o
);
    logic [7:0] cnt_reg;
    // count bus time, pulse done once
    always_ff @(posedge clk_i) begin
        cnt_reg   <= (rst_i || !tx_valid_i || tx_done_o) ? 8'h00 : cnt_reg + 8'h01;
        tx_done_o <= !rst_i && tx_valid_i && !tx_done_o && cnt_reg >= lat_i;
    end
endmodule : cfs_bus_model

// File: tb/cfs_sched_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// scheduler bench
module cfs_sched_tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, trig = 1'b0;
    logic        rxv = 1'b0, rtr = 1'b0, tq = 1'b0, ack, aen, txv, trtr, done, rxr;
    logic [7:0]  adr = 8'h00, lat = 8'h02;
    logic [10:0] rxid = 11'h000, tid, txid;
    logic [31:0] wd = 32'h0, rdat, rd;
    logic [63:0] rxd = 64'h0, pay, txd;
    logic [75:0] last;
    int          num_errors = 0, total_checks = 0, cn = 0, ns = 0, tr = 0, tp = 0, k = 0, ts;
    // design and remote controller
    cfs_sched #(.FIFO_DEPTH(4)) u_cfs_sched (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
        .wb_dat_o(rdat), .wb_ack_o(ack), .trig_i(trig), .ack_en_o(aen), .tx_valid_o(txv),
        .tx_id_o(txid), .tx_rtr_o(trtr), .tx_data_o(txd), .tx_done_i(done),
        .rx_valid_i(rxv), .rx_ready_o(rxr), .rx_id_i(rxid), .rx_rtr_i(rtr), .rx_data_i(rxd));
    cfs_bus_model u_cfs_bus_model (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(txv),
        .lat_i(lat), .tx_done_o(done));
    always #25 clk_i = ~clk_i;
    // cycle count, launch times, last finished frame
    always @(posedge clk_i) begin
        cn <= rst_i ? 0 : cn + 1;
        tq <= txv;
        if (txv && !tq) {tp, tr} <= {tr, cn};
        if (txv && done) {ns, last} <= {ns + 1, trtr, txid, txd};
    end
    task automatic chk(input logic [75:0] g, e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %0h exp %0h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, we, adr, wd} <= {1'b1, w, a, d};
        do @(posedge clk_i); while (!ack);
        rd = rdat;
        cyc <= 1'b0;
        chk(ack, 1'b1);
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic rxf(input logic r, input logic [10:0] i, input logic [63:0] d);
        @(posedge clk_i);
        {rxv, rtr, rxid, rxd} <= {1'b1, r, i, d};
        do @(posedge clk_i); while (!rxr);
        {rxv, rxd} <= {1'b0, ~d};
    endtask : rxf
    task automatic wt(input int t);
        for (int n = 0; ns < t && n < 2000; n++) @(posedge clk_i);
    endtask : wt
    task automatic halt();
        wb(1'b1, 8'h00, 32'h0);
        repeat (4) @(posedge clk_i);
        k = ns;
    endtask : halt
    function automatic logic [31:0] ctl(input logic [1:0] m, s, input logic o, e, t);
        return {23'h0, s, t, e, m, o, 2'b11};
    endfunction : ctl
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // watchdog
    initial begin
        #1000000;
        num_errors++;
        conclude();
    end
    // scenarios
    initial begin
        ts = $urandom(32'h05927D8E);
        {pay, tid} = {$urandom, $urandom, 11'($urandom)};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        lat <= 8'($urandom % 7);
        rdc(8'h04, 32'h0000_00C8);
        rdc(8'h3C, 32'h0);
        wb(1'b1, 8'h04, 32'h14);
        wb(1'b1, 8'h08, 32'(tid));
        wb(1'b1, 8'h0C, pay[31:0]);
        wb(1'b1, 8'h10, pay[63:32]);
        wb(1'b1, 8'h00, ctl(2'h0, 2'h0, 1'b1, 1'b0, 1'b0));
        wb(1'b1, 8'h14, 32'h0);
        wt(ns + 3);
        chk(last, {1'b0, tid, pay});
        chk(tr - tp, 20);
        halt();
        // event output; a remote write is dropped
        wb(1'b1, 8'h00, ctl(2'h1, 2'h0, 1'b1, 1'b1, 1'b0));
        wb(1'b1, 8'h14, 32'h800);
        repeat (40) @(posedge clk_i);
        chk(ns, k);
        wb(1'b1, 8'h14, 32'h0);
        wt(k + 1);
        wb(1'b1, 8'h14, 32'h0);
        wt(k + 2);
        chk(tr - tp >= 20, 1'b1);
        repeat (60) @(posedge clk_i);
        chk(ns, k + 2);
        halt();
        // stream output in each timing
        for (int s = 0; s < 3; s++) begin
            ts = cn + 80;
            wb(1'b1, 8'h00, ctl(2'h2, 2'(s), 1'b1, 1'b0, 1'b0));
            wb(1'b1, 8'h18, 32'(ts));
            wb(1'b1, 8'h14, {20'h0, s == 1, tid});
            wt(k + 1);
            chk(last[75:64], {s == 1, tid});
            chk(s == 0 || tr + 2 >= ts, 1'b1);
            repeat (60) @(posedge clk_i);
            chk(ns, k + 1);
            halt();
        end
        // single-point and queued input
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, 8'h00, ctl(2'(m), 2'h0, 1'b0, 1'b0, 1'b0));
            rxf(1'b1, tid, ~pay);
            rdc(8'h1C, 32'h3);
            rxf(1'b0, tid, pay);
            rdc(8'h24, pay[31:0]);
            rdc(8'h28, pay[63:32]);
            halt();
        end
        // stream input fills the buffer, drains in order
        wb(1'b1, 8'h00, ctl(2'h2, 2'h0, 1'b0, 1'b0, 1'b0));
        for (int i = 0; i < 4; i++) rxf(i[0], 11'(i), pay);
        @(posedge clk_i);
        chk(rxr, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rdc(8'h20, {20'h0, i[0], 11'(i)});
            rdc(8'h28, pay[63:32]);
        end
        halt();
        // start waits for a fresh trigger edge
        trig <= 1'b1;
        wb(1'b1, 8'h00, ctl(2'h0, 2'h0, 1'b1, 1'b0, 1'b1));
        repeat (40) @(posedge clk_i);
        chk(ns, k);
        trig <= 1'b0;
        repeat (2) @(posedge clk_i);
        trig <= 1'b1;
        wt(k + 1);
        chk(ns, k + 1);
        conclude();
    end
endmodule : cfs_sched_tb_top
